// >>> common/csr_params.svh
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH
// Control byte fields
`define CSR_CB_REGMODE 7
`define CSR_CB_RW 6
`define CSR_CB_ERRCLR 6
`define CSR_CB_ENABLE 5
`define CSR_CB_VIEW 4
`define CSR_CB_FALL 3
`define CSR_CB_RISE 2
`define CSR_CB_POSITION_LOAD_REQUEST 1
// Status byte fields
`define CSR_SB_REGMODE 7
`define CSR_SB_ERROR 6
`define CSR_SB_WARN 5
`define CSR_SB_READY 4
`define CSR_SB_SHOWN 3
`define CSR_SB_CAPT 2
`define CSR_SB_POSACK 1
`define CSR_SB_AUX 0
// Register indices
`define CSR_IDX_FAULT 6'h00
`define CSR_IDX_PRESET 6'h01
`define CSR_IDX_COIL 6'h02
`define CSR_IDX_SUPPLY 6'h03
`define CSR_IDX_TEMP 6'h05
`define CSR_IDX_SBMIR 6'h06
`define CSR_IDX_CMD 6'h07
`define CSR_IDX_TYPE 6'h08
`define CSR_IDX_FW 6'h09
`define CSR_IDX_MUX 6'h0a
`define CSR_IDX_SIG 6'h0b
`define CSR_IDX_MINLEN 6'h0c
`define CSR_IDX_STRUCT 6'h0d
`define CSR_IDX_ALIGN 6'h0f
`define CSR_IDX_HWREV 6'h10
// Reset and fixed values
`define CSR_RST_PRESET 16'h0000
`define CSR_RST_CMD 16'h0000
`define CSR_VAL_MUX 16'h0130
`define CSR_VAL_SIG 16'h0218
`define CSR_VAL_MINLEN 16'h1818
`define CSR_VAL_STRUCT 16'h0004
`define CSR_RST_ALIGN 16'h7f80
`define CSR_RST_HWREV 16'h0000
// Warning thresholds in degrees C
`define CSR_TEMP_HIGH 16'h0050
`define CSR_TEMP_LOW 16'h003c
`endif

// >>> common/csr_pkg.sv
package csr_pkg;
   typedef enum logic [1:0] {
      CSR_MODE_PROC,
      CSR_MODE_REG
   } csr_mode_t;
   typedef logic [15:0] csr_word_t;
endpackage

// >>> rtl/csr_channel.sv
`timescale 1ns/10ps
`include "csr_params.svh"
module csr_channel #(
   parameter logic [15:0] TYPE_CODE = 16'h1234, // Arbitrary value
   parameter logic [15:0] FW_REV = 16'h0001     // Arbitrary value
) (
   input wire logic clk_i,                        // Clock
   input wire logic nrst_i,                       // Async reset, low
   input wire logic [7:0] control_byte_i,         // Control byte from controller
   input wire logic [15:0] output_word_i,         // Output word from controller
   input wire logic [15:0] fault_i,               // Fault causes, level
   input wire logic [15:0] coil_i,                // Coil voltage, mV
   input wire logic [15:0] supply_i,              // Supply voltage, mV
   input wire logic [15:0] temp_i,                // Temperature, degrees C
   input wire logic supply_low_i,                 // Supply dropped
   input wire logic capture_event_i,              // Capture event pulse
   input wire logic [15:0] position_i,            // Current position
   input wire logic position_loaded_i,            // Position load done pulse
   input wire logic auxiliary_input_level_i,      // Auxiliary input
   output logic [7:0] status_byte_o,              // Status byte to controller
   output logic [15:0] input_word_o,              // Input word to controller
   output logic enable_o,                         // Output control enabled
   output logic position_load_request_o,          // Load pulse
   output logic [15:0] position_preset_o,         // Preset value
   output logic [15:0] command_o,                 // Command register
   output logic command_wr_o                      // Command written pulse
);
   csr_pkg::csr_word_t fault_r, fault_nxt, preset_r, preset_nxt, capt_val_r, capt_val_nxt;
   csr_pkg::csr_word_t cmd_r, cmd_nxt, align_r, align_nxt, hwrev_r, hwrev_nxt;
   csr_pkg::csr_word_t rdata;
   logic [7:0] sb_r, sb_nxt;
   logic [15:0] iw_r, iw_nxt;
   logic warn_r, warn_nxt, capt_r, capt_nxt, ack_r, ack_nxt;
   logic errclr_d_r, errclr_d_nxt, position_load_request_d_r, position_load_request_d_nxt, req_r, req_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic regm, pd_sb;
   logic [5:0] idx;
   logic [7:0] pd_byte;

   assign regm = control_byte_i[`CSR_CB_REGMODE];
   assign idx = control_byte_i[5:0];

   // Register read mux; reserved indices read zero
   always_comb begin
      rdata = 16'h0000;
      unique case (idx)
         `CSR_IDX_FAULT: rdata = fault_r;
         `CSR_IDX_PRESET: rdata = preset_r;
         `CSR_IDX_COIL: rdata = coil_i; // RULE_16
         `CSR_IDX_SUPPLY: rdata = supply_i;
         `CSR_IDX_TEMP: rdata = temp_i; // RULE_17
         `CSR_IDX_SBMIR: rdata = {8'h00, pd_byte};
         `CSR_IDX_CMD: rdata = cmd_r;
         `CSR_IDX_TYPE: rdata = TYPE_CODE;
         `CSR_IDX_FW: rdata = FW_REV;
         `CSR_IDX_MUX: rdata = `CSR_VAL_MUX;
         `CSR_IDX_SIG: rdata = `CSR_VAL_SIG;
         `CSR_IDX_MINLEN: rdata = `CSR_VAL_MINLEN;
         `CSR_IDX_STRUCT: rdata = `CSR_VAL_STRUCT;
         `CSR_IDX_ALIGN: rdata = align_r;
         `CSR_IDX_HWREV: rdata = hwrev_r;
         default: rdata = 16'h0000;
      endcase
   end

   // Process data status byte, also mirrored at index 6
   assign pd_sb = fault_r != 16'h0000;
   always_comb begin
      pd_byte = 8'h00;
      pd_byte[`CSR_SB_REGMODE] = 1'b0; // RULE_01
      pd_byte[`CSR_SB_ERROR] = pd_sb; // RULE_02
      pd_byte[`CSR_SB_WARN] = warn_r; // RULE_03
      pd_byte[`CSR_SB_READY] = enable_o & ~pd_sb; // RULE_04
      pd_byte[`CSR_SB_SHOWN] = control_byte_i[`CSR_CB_VIEW] & capt_r; // RULE_05
      pd_byte[`CSR_SB_CAPT] = capt_r; // RULE_06
      pd_byte[`CSR_SB_POSACK] = ack_r; // RULE_07
      pd_byte[`CSR_SB_AUX] = auxiliary_input_level_i;
   end

   // Next state of the channel
   always_comb begin
      fault_nxt = fault_r | fault_i;
      preset_nxt = preset_r;
      capt_val_nxt = capt_val_r;
      cmd_nxt = cmd_r;
      align_nxt = align_r;
      hwrev_nxt = hwrev_r;
      warn_nxt = warn_r;
      capt_nxt = capt_r;
      ack_nxt = ack_r;
      req_nxt = 1'b0;
      wr_pend_nxt = 1'b0;
      errclr_d_nxt = errclr_d_r;
      position_load_request_d_nxt = position_load_request_d_r;
      sb_nxt = sb_r;
      iw_nxt = iw_r;
      // Hysteresis keeps the warning from chattering near the threshold
      if (temp_i > `CSR_TEMP_HIGH || supply_low_i) begin
         warn_nxt = 1'b1; // RULE_03
      end else if (temp_i < `CSR_TEMP_LOW) begin
         warn_nxt = 1'b0;
      end
      if (regm) begin
         // Edge history is frozen so mode switching does not fake an edge
         if (control_byte_i[`CSR_CB_RW]) begin
            // Only writable indices update; read-only ones ignore writes
            unique case (idx)
               `CSR_IDX_PRESET: preset_nxt = output_word_i; // RULE_10 RULE_15
               `CSR_IDX_CMD: begin
                  cmd_nxt = output_word_i;
                  wr_pend_nxt = ~(sb_r[`CSR_SB_REGMODE] && sb_r[5:0] == idx && sb_r[6]);
               end
               `CSR_IDX_ALIGN: align_nxt = output_word_i;
               `CSR_IDX_HWREV: hwrev_nxt = output_word_i;
               default: ;
            endcase
         end else begin
            iw_nxt = rdata; // RULE_10 RULE_14
         end
         sb_nxt = {1'b1, control_byte_i[`CSR_CB_RW], idx}; // RULE_11 RULE_12
      end else begin
         errclr_d_nxt = control_byte_i[`CSR_CB_ERRCLR];
         position_load_request_d_nxt = control_byte_i[`CSR_CB_POSITION_LOAD_REQUEST];
         // Error clear on rising edge; a fault still present sets again
         if (control_byte_i[`CSR_CB_ERRCLR] && !errclr_d_r) begin
            fault_nxt = fault_i; // RULE_02
         end
         if (control_byte_i[`CSR_CB_POSITION_LOAD_REQUEST] && !position_load_request_d_r) begin
            req_nxt = 1'b1;
            ack_nxt = 1'b0;
         end
         if (!control_byte_i[`CSR_CB_POSITION_LOAD_REQUEST]) begin
            ack_nxt = 1'b0;
         end
         if (position_loaded_i) begin
            ack_nxt = 1'b1; // RULE_07
         end
         if (!control_byte_i[`CSR_CB_RISE] && !control_byte_i[`CSR_CB_FALL]) begin
            capt_nxt = 1'b0;
         end
         // Capture set wins over the clear above
         if (capture_event_i && (control_byte_i[`CSR_CB_RISE] ||
                                 control_byte_i[`CSR_CB_FALL])) begin
            capt_nxt = 1'b1; // RULE_06
            capt_val_nxt = position_i;
         end
         sb_nxt = pd_byte;
         iw_nxt = pd_byte[`CSR_SB_SHOWN] ? capt_val_r : position_i; // RULE_05
      end
   end

   // State registers
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fault_r <= 16'h0000;
         preset_r <= `CSR_RST_PRESET;
         capt_val_r <= 16'h0000;
         cmd_r <= `CSR_RST_CMD;
         align_r <= `CSR_RST_ALIGN;
         hwrev_r <= `CSR_RST_HWREV;
         warn_r <= 1'b0;
         capt_r <= 1'b0;
         ack_r <= 1'b0;
         req_r <= 1'b0;
         wr_pend_r <= 1'b0;
         errclr_d_r <= 1'b0;
         position_load_request_d_r <= 1'b0;
         sb_r <= 8'h00;
         iw_r <= 16'h0000;
      end else begin
         fault_r <= fault_nxt;
         preset_r <= preset_nxt;
         capt_val_r <= capt_val_nxt;
         cmd_r <= cmd_nxt;
         align_r <= align_nxt;
         hwrev_r <= hwrev_nxt;
         warn_r <= warn_nxt;
         capt_r <= capt_nxt;
         ack_r <= ack_nxt;
         req_r <= req_nxt;
         wr_pend_r <= wr_pend_nxt;
         errclr_d_r <= errclr_d_nxt;
         position_load_request_d_r <= position_load_request_d_nxt;
         sb_r <= sb_nxt;
         iw_r <= iw_nxt;
      end
   end

   // Enable held from the last process data control byte
   logic en_r, en_nxt;
   always_comb begin
      en_nxt = regm ? en_r : control_byte_i[`CSR_CB_ENABLE];
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         en_r <= 1'b0;
      end else begin
         en_r <= en_nxt;
      end
   end

   assign enable_o = en_r;
   assign status_byte_o = sb_r;
   assign input_word_o = iw_r;
   assign position_load_request_o = req_r;
   assign position_preset_o = preset_r;
   assign command_o = cmd_r;
   assign command_wr_o = wr_pend_r;
endmodule

// >>> rtl/csr_top.sv
`timescale 1ns/10ps
// Contract
// RULE_01: Process mode status shows register bit zero
// RULE_02: Error bit set while fault recorded
// RULE_03: Warning on overtemperature or supply drop
// RULE_04: Ready means enabled and no error
// RULE_05: Shown bit tells position or capture
// RULE_06: Capture bit set on enabled event
// RULE_07: Load acknowledge after position loaded
// RULE_08: Controller sets top bit for registers
// RULE_09: Controller gives direction and index
// RULE_10: Reads return word, writes take word
// RULE_11: Register access acknowledged with top bit
// RULE_12: Echo index and direction in status
// RULE_13: Second channel identical to first
// RULE_14: Registers reachable only through control bytes
// RULE_15: Preset register index one, reset zero
// RULE_16: Coil voltage read-only, index two
// RULE_17: Temperature read-only at index five
// RULE_18: Controller clears top bit for process
// RULE_19: Controller holds request until echoed
module csr_top #(
   parameter logic [15:0] TYPE_CODE = 16'h1234, // Arbitrary value
   parameter logic [15:0] FW_REV = 16'h0001     // Arbitrary value
) (
   input wire logic clk_i,                              // Clock, 10 MHz
   input wire logic nrst_i,                             // Async reset, low
   input wire logic [7:0] first_channel_control_byte_i, // Channel 1 control
   input wire logic [15:0] ch1_output_word_i,           // Channel 1 output word
   input wire logic [7:0] second_channel_control_byte_i,// Channel 2 control
   input wire logic [15:0] ch2_output_word_i,           // Channel 2 output word
   input wire logic [31:0] fault_i,                     // Faults, ch2 high half
   input wire logic [31:0] coil_i,                      // Coil voltages
   input wire logic [31:0] supply_i,                    // Supply voltages
   input wire logic [31:0] temp_i,                      // Temperatures
   input wire logic [1:0] supply_low_i,                 // Supply dropped
   input wire logic [1:0] capture_event_i,              // Capture pulses
   input wire logic [31:0] position_i,                  // Current positions
   input wire logic [1:0] position_loaded_i,            // Load done pulses
   input wire logic [1:0] auxiliary_input_level_i,      // Aux inputs
   output logic [7:0] first_channel_status_byte_o,      // Channel 1 status
   output logic [15:0] ch1_input_word_o,                // Channel 1 input word
   output logic [7:0] second_channel_status_byte_o,     // Channel 2 status
   output logic [15:0] ch2_input_word_o,                // Channel 2 input word
   output logic [1:0] enable_o,                         // Output enables
   output logic [1:0] position_load_request_o,          // Load pulses
   output logic [31:0] position_preset_o,               // Preset values
   output logic [31:0] command_o,                       // Command registers
   output logic [1:0] command_wr_o                      // Command write pulses
);
   logic [7:0] cb [2];
   logic [15:0] ow [2];
   logic [7:0] sb [2];
   logic [15:0] iw [2];
   assign cb[0] = first_channel_control_byte_i;
   assign cb[1] = second_channel_control_byte_i;
   assign ow[0] = ch1_output_word_i;
   assign ow[1] = ch2_output_word_i;

   // Both channels share one implementation
   for (genvar g = 0; g < 2; g++) begin : g_ch
      csr_channel #(.TYPE_CODE(TYPE_CODE), .FW_REV(FW_REV)) u_ch ( // RULE_13
         .clk_i(clk_i),
         .nrst_i(nrst_i),
         .control_byte_i(cb[g]),
         .output_word_i(ow[g]),
         .fault_i(fault_i[16*g +: 16]),
         .coil_i(coil_i[16*g +: 16]),
         .supply_i(supply_i[16*g +: 16]),
         .temp_i(temp_i[16*g +: 16]),
         .supply_low_i(supply_low_i[g]),
         .capture_event_i(capture_event_i[g]),
         .position_i(position_i[16*g +: 16]),
         .position_loaded_i(position_loaded_i[g]),
         .auxiliary_input_level_i(auxiliary_input_level_i[g]),
         .status_byte_o(sb[g]),
         .input_word_o(iw[g]),
         .enable_o(enable_o[g]),
         .position_load_request_o(position_load_request_o[g]),
         .position_preset_o(position_preset_o[16*g +: 16]),
         .command_o(command_o[16*g +: 16]),
         .command_wr_o(command_wr_o[g])
      );
   end

   assign first_channel_status_byte_o = sb[0];
   assign second_channel_status_byte_o = sb[1];
   assign ch1_input_word_o = iw[0];
   assign ch2_input_word_o = iw[1];
endmodule

// >>> testbench/csr_top_sva.sv
`timescale 1ns/10ps
module csr_top_chk (
   input wire logic clk_i,                               // Clock
   input wire logic nrst_i,                              // Reset, low
   input wire logic [7:0] first_channel_control_byte_i,  // Ch1 control
   input wire logic [15:0] ch1_output_word_i,            // Ch1 output word
   input wire logic [7:0] second_channel_control_byte_i, // Ch2 control
   input wire logic [31:0] fault_i,                      // Fault causes
   input wire logic [31:0] temp_i,                       // Temperatures
   input wire logic [1:0] capture_event_i,               // Capture pulses
   input wire logic [1:0] position_loaded_i,             // Load done pulses
   input wire logic [7:0] first_channel_status_byte_o,   // Ch1 status
   input wire logic [15:0] ch1_input_word_o,             // Ch1 input word
   input wire logic [7:0] second_channel_status_byte_o,  // Ch2 status
   input wire logic [1:0] enable_o,                      // Enables
   input wire logic [1:0] position_load_request_o,       // Load pulses
   input wire logic [31:0] position_preset_o             // Presets
);
   wire logic [7:0] cb;
   wire logic [7:0] sb;
   // Short aliases for channel one
   assign cb = first_channel_control_byte_i;
   assign sb = first_channel_status_byte_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   proc_ack_a: assert property (!cb[7] |=> !sb[7])
      else $error("register bit shown in process mode");
   reg_echo_a: assert property (cb[7] |=> sb == $past(cb))
      else $error("channel one echo wrong");
   ch2_echo_a: assert property (second_channel_control_byte_i[7] |=>
      second_channel_status_byte_o == $past(second_channel_control_byte_i))
      else $error("channel two echo wrong");
   err_set_a: assert property ((!cb[7] && fault_i[15:0] != 16'h0000) [*2] |=> sb[6])
      else $error("error bit missing");
   ready_ok_a: assert property (!sb[7] && sb[4] |-> $past(enable_o[0]) && !sb[6])
      else $error("ready without enable or with error");
   warn_set_a: assert property ((!cb[7] && temp_i[15:0] > 16'h0050) [*2] |=> sb[5])
      else $error("warning bit missing");
   capt_set_a: assert property (!cb[7] && cb[2] && capture_event_i[0] ##1
      !cb[7] && cb[2] |=> sb[2])
      else $error("capture flag missing");
   load_req_a: assert property (!$past(cb[7]) && !cb[7] && $rose(cb[1]) |=>
      position_load_request_o[0] ##1 !position_load_request_o[0])
      else $error("load request not a single pulse");
   load_ack_a: assert property (!cb[7] && cb[1] && position_loaded_i[0] ##1
      !cb[7] && cb[1] |=> sb[1])
      else $error("load acknowledge missing");
   preset_wr_a: assert property (cb == 8'hc1 |=>
      position_preset_o[15:0] == $past(ch1_output_word_i))
      else $error("preset write lost");
   preset_rd_a: assert property (cb == 8'h81 [*2] |=>
      ch1_input_word_o == $past(position_preset_o[15:0]))
      else $error("preset read wrong");
   // Main scenarios seen at least once
   cov_wr_c: cover property (cb == 8'hc1);
   cov_err_c: cover property (sb[6] && !sb[7]);
   cov_ack_c: cover property (sb[1] && !sb[7]);
endmodule
bind csr_top csr_top_chk u_chk (.clk_i, .nrst_i, .first_channel_control_byte_i,
   .ch1_output_word_i, .second_channel_control_byte_i, .fault_i, .temp_i, .capture_event_i,
   .position_loaded_i, .first_channel_status_byte_o, .ch1_input_word_o,
   .second_channel_status_byte_o, .enable_o, .position_load_request_o, .position_preset_o);

// >>> testbench/csr_ctl_model.sv
`timescale 1ns/10ps
module csr_ctl_model (
   input wire logic clk_i,     // Clock
   input wire logic [7:0] sb_i, // Status byte
   input wire logic [15:0] iw_i, // Input word
   output logic [7:0] cb_o,    // Control byte
   output logic [15:0] ow_o    // Output word
);
   int slow = 0;
   // Idle in process mode with everything off
   initial begin
      cb_o = 8'h00;
      ow_o = 16'h0000;
   end
   // Request held until the matching echo; slow adds idle cycles after it.
   // The echo is looked at on the falling edge, once the launching edge has settled it.
   task automatic acc(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
         output logic [15:0] rd, output bit ok);
      logic [7:0] req;
      req = {1'b1, wr, idx};
      ok = 1'b0;
      rd = 16'h0000;
      @(negedge clk_i);
      cb_o = req;
      ow_o = wr ? wd : ~ow_o;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(negedge clk_i);
         if (sb_i === req) begin
            ok = 1'b1;
            rd = iw_i;
         end
      end
      repeat (slow) @(negedge clk_i);
   endtask
   // Process mode: top bit cleared, rest are controls
   task automatic proc(input logic [6:0] ctl);
      @(negedge clk_i);
      cb_o = {1'b0, ctl};
   endtask
endmodule

// >>> testbench/csr_top_bench.sv
`timescale 1ns/10ps
module csr_top_bench;
   localparam logic [5:0] RIDX [0:10] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h07, 6'h0a, 6'h0b,
      6'h0c, 6'h0d, 6'h0e, 6'h0f};
   localparam logic [15:0] RVAL [0:10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0130, 16'h0218, 16'h1818, 16'h0004, 16'h0000, 16'h7f80};
   logic clk, nrst;
   logic [7:0] cb1, cb2, sb1, sb2;
   logic [15:0] ow1, ow2, iw1, iw2, d;
   logic [31:0] fault, coil, supply, temp, pos, preset, cmd;
   logic [1:0] low, cap, loaded, aux, en, lreq, cwr;
   int n_fail = 0;
   int check_count = 0;
   int n_lreq = 0;
   int n_cwr = 0;
   // Type and firmware codes are arbitrary
   csr_top #(.TYPE_CODE(16'h4321), .FW_REV(16'h0002)) u_dut (.clk_i(clk), .nrst_i(nrst),
      .first_channel_control_byte_i(cb1), .ch1_output_word_i(ow1),
      .second_channel_control_byte_i(cb2), .ch2_output_word_i(ow2), .fault_i(fault),
      .coil_i(coil), .supply_i(supply), .temp_i(temp), .supply_low_i(low),
      .capture_event_i(cap), .position_i(pos), .position_loaded_i(loaded),
      .auxiliary_input_level_i(aux), .first_channel_status_byte_o(sb1),
      .ch1_input_word_o(iw1), .second_channel_status_byte_o(sb2), .ch2_input_word_o(iw2),
      .enable_o(en), .position_load_request_o(lreq), .position_preset_o(preset),
      .command_o(cmd), .command_wr_o(cwr));
   csr_ctl_model u_c1 (.clk_i(clk), .sb_i(sb1), .iw_i(iw1), .cb_o(cb1), .ow_o(ow1));
   csr_ctl_model u_c2 (.clk_i(clk), .sb_i(sb2), .iw_i(iw2), .cb_o(cb2), .ow_o(ow2));
   // Clock at 10 MHz
   always #50 clk = ~clk;
   // One-cycle pulses counted on the falling edge, where they have settled
   always @(negedge clk) begin
      n_lreq += $countones(lreq);
      n_cwr += $countones(cwr);
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One register access; a missing echo ends the run
   task automatic acc(input int ch, input logic wr, input logic [5:0] idx,
         input logic [15:0] wd);
      bit ok;
      if (ch == 1) u_c1.acc(wr, idx, wd, d, ok);
      else u_c2.acc(wr, idx, wd, d, ok);
      @(negedge clk);
      if (!ok) begin
         n_fail++;
         $display("MISMATCH t=%0t no echo", $time);
         end_sim();
      end
   endtask
   task automatic rd(input int ch, input logic [5:0] idx, input logic [15:0] exp);
      acc(ch, 1'b0, idx, 16'h0000);
      chk(d, exp);
   endtask
   // Status bytes settle within two cycles of a change
   task automatic sbc(input logic [7:0] e1, input logic [7:0] e2);
      repeat (3) @(negedge clk);
      chk({8'h00, sb1}, {8'h00, e1});
      chk({8'h00, sb2}, {8'h00, e2});
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("MISMATCH t=%0t timeout", $time);
      end_sim();
   end
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      fault = 32'h0000_0000;
      coil = 32'h0000_0000;
      supply = 32'h0030_0030;
      temp = 32'h0023_0023;
      low = 2'b00;
      cap = 2'b00;
      pos = 32'h0000_0000;
      loaded = 2'b00;
      aux = 2'b01;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      for (int c = 1; c <= 2; c++) begin
         for (int i = 0; i < 11; i++) rd(c, RIDX[i], RVAL[i]);
      end
      rd(1, 6'h08, 16'h4321);
      rd(2, 6'h09, 16'h0002);
      rd(1, 6'h10, 16'h0000);
      supply = 32'h0028_0029;
      rd(1, 6'h03, 16'h0029);
      rd(2, 6'h03, 16'h0028);
      $display("test reset_values done");
      coil = 32'h0bb8_12c0;
      acc(1, 1'b1, 6'h01, 16'habcd);
      chk(preset[15:0], 16'habcd);
      acc(1, 1'b1, 6'h02, 16'hffff);
      rd(1, 6'h02, 16'h12c0);
      rd(1, 6'h05, 16'h0023);
      acc(1, 1'b1, 6'h04, 16'h1234);
      rd(1, 6'h04, 16'h0000);
      acc(1, 1'b1, 6'h07, 16'h0042);
      chk(cmd[15:0], 16'h0042);
      u_c2.slow = 2;
      acc(2, 1'b1, 6'h01, 16'h5a5a);
      rd(2, 6'h01, 16'h5a5a);
      rd(2, 6'h02, 16'h0bb8);
      chk(preset[15:0], 16'habcd);
      $display("test register_access done");
      u_c2.proc(7'h20);
      u_c1.proc(7'h20);
      sbc(8'h11, 8'h10);
      fault = 32'h0000_1000;
      sbc(8'h41, 8'h10);
      rd(1, 6'h00, 16'h1000);
      fault = 32'h0000_0000;
      u_c1.proc(7'h60);
      u_c1.proc(7'h20);
      sbc(8'h11, 8'h10);
      u_c1.proc(7'h00);
      sbc(8'h01, 8'h10);
      chk({14'h0000, en}, 16'h0002);
      u_c1.proc(7'h20);
      temp = 32'h0023_0050;
      sbc(8'h11, 8'h10);
      temp = 32'h0023_0051;
      sbc(8'h31, 8'h10);
      temp = 32'h0023_003b;
      sbc(8'h11, 8'h10);
      low = 2'b01;
      sbc(8'h31, 8'h10);
      low = 2'b00;
      sbc(8'h11, 8'h10);
      $display("test status_flags done");
      u_c1.proc(7'h24);
      @(negedge clk);
      pos = 32'h0000_1111;
      cap = 2'b01;
      @(negedge clk);
      cap = 2'b00;
      pos = 32'h0000_2222;
      sbc(8'h15, 8'h10);
      chk(iw1, 16'h2222);
      u_c1.proc(7'h34);
      sbc(8'h1d, 8'h10);
      chk(iw1, 16'h1111);
      u_c1.proc(7'h20);
      sbc(8'h11, 8'h10);
      u_c1.proc(7'h22);
      @(negedge clk);
      loaded = 2'b01;
      @(negedge clk);
      loaded = 2'b00;
      sbc(8'h13, 8'h10);
      u_c1.proc(7'h20);
      sbc(8'h11, 8'h10);
      $display("test process_mode done");
      aux = 2'b10;
      sbc(8'h10, 8'h11);
      fault = 32'h2000_0000;
      temp = 32'h0051_0023;
      sbc(8'h10, 8'h61);
      rd(2, 6'h00, 16'h2000);
      fault = 32'h0000_0000;
      temp = 32'h0023_0023;
      u_c2.proc(7'h60);
      u_c2.proc(7'h20);
      sbc(8'h10, 8'h11);
      low = 2'b10;
      sbc(8'h10, 8'h31);
      low = 2'b00;
      u_c2.proc(7'h28);
      @(negedge clk);
      pos = 32'h3333_0000;
      cap = 2'b10;
      @(negedge clk);
      cap = 2'b00;
      pos = 32'h4444_0000;
      u_c2.proc(7'h38);
      sbc(8'h10, 8'h1d);
      chk(iw2, 16'h3333);
      u_c2.proc(7'h22);
      @(negedge clk);
      loaded = 2'b10;
      @(negedge clk);
      loaded = 2'b00;
      sbc(8'h10, 8'h13);
      chk(16'(n_lreq), 16'h0002);
      chk(16'(n_cwr), 16'h0001);
      rd(1, 6'h06, 16'h0010);
      $display("test channel_two done");
      nrst = 1'b0;
      @(negedge clk);
      nrst = 1'b1;
      chk({8'h00, sb2}, 16'h0000);
      rd(1, 6'h01, 16'h0000);
      rd(2, 6'h01, 16'h0000);
      $display("test mid_reset done");
      end_sim();
   end
endmodule
